//--- jtd_pkg.sv
// Constants, types and helpers of the test access port and debug block
//---------------------------------------------------------------------
// Notes on behaviour
// - Sixteen-state controller stepped by TMS at TCK rise
// - Power-on reset starts in Test-Logic-Reset
// - All shift registers move LSB first
// - Four-bit instruction, last bit shifts on exit
// - Instruction shift outputs captured value 0x01
// - Instruction takes effect only in Update-IR
// - Instruction picks data path and its logic
// - Shift-DR outputs values captured in Capture-DR
// - Latched outputs change only in Update-DR
// - Exit and pause states do no register action
// - Five TMS-high periods reach Test-Logic-Reset
// - No test reset pin; reset by power, gating, TMS
// - Unprogrammed port fuse: plain pins, controller reset
// - Fuse set, disable clear: pull-ups, port enabled
// - Debug needs both fuses and no lock bit
// - ID, bypass, boundary, CPU and break chains
// - Break on flow change and single step
// - Two program points, two combined or range
// - CPU chain feeds instructions; comm byte read back
// - Bypass stage cleared leaving Capture-DR
//---------------------------------------------------------------------
package jtd_pkg;
    localparam int IRW = 4;
    localparam int BSW = 8;
    localparam int PCW = 16;
    localparam int INW = 16;
    localparam int CMW = 8;
    localparam int NBP = 4;
    localparam int DRW = 73;
    localparam int SYW = 7;
    // Break chain layout: four addresses, then mode bits
    localparam int BF_EN   = 64;
    localparam int BF_D2   = 68;
    localparam int BF_D3   = 69;
    localparam int BF_MASK = 70;
    localparam int BF_FLOW = 71;
    localparam int BF_STEP = 72;
    // Chain lengths per selected path
    localparam int LEN_BYP  = 1;
    localparam int LEN_ID   = 32;
    localparam int LEN_CPU  = INW;
    localparam int LEN_COMM = CMW + 1;
    // Synchroniser bit order
    localparam int SY_TCK = 6;
    localparam int SY_TMS = 5;
    localparam int SY_TDI = 4;
    localparam int SY_TPF = 3;
    localparam int SY_DBF = 2;
    localparam int SY_LB1 = 1;
    localparam int SY_LB2 = 0;
    // Instruction codes
    localparam logic [3:0] IR_EXTEST  = 4'h0;
    localparam logic [3:0] IR_IDCODE  = 4'h1;
    localparam logic [3:0] IR_SAMPLE  = 4'h2;
    localparam logic [3:0] IR_CPU     = 4'h8;
    localparam logic [3:0] IR_BRK     = 4'h9;
    localparam logic [3:0] IR_COMM    = 4'ha;
    localparam logic [3:0] IR_BYPASS  = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // Register map and fields
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_COMM = 8'h08;
    localparam int CT_DIS  = 0;
    localparam int ST_TAP  = 0;
    localparam int ST_IR   = 4;
    localparam int ST_PUP  = 8;
    localparam int ST_DBG  = 9;
    localparam int ST_DIRT = 10;
    localparam int ST_BRK  = 11;
    localparam int CM_DIRT = 7;

    typedef enum logic [3:0] {
        TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PSDR, EX2DR, UPDDR,
        SELIR, CAPIR, SHIR, EX1IR, PSIR, EX2IR, UPDIR
    } jtd_tap_t;

    typedef struct packed {
        logic [SYW-1:0] s1;
        logic [SYW-1:0] s2;
        logic           tck_d;
        jtd_tap_t       tap;
        logic [IRW-1:0] ir_sh;
        logic [IRW-1:0] ir;
        logic [DRW-1:0] dr;
        logic [BSW-1:0] bs_out;
        logic           bs_drive;
        logic [INW-1:0] cpu_insn;
        logic           cpu_vld;
        logic [DRW-1:0] bp_cfg;
        logic [CMW-1:0] comm;
        logic           dirty;
        logic           brk;
        logic           dbg_act;
        logic           pup;
        logic           port_dis;
        logic           tdo;
        logic           tdo_oe_n;
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
    } jtd_st_t;

    localparam jtd_st_t RST_ST = '{tap: TLR, ir: IR_IDCODE, tdo_oe_n: 1'b1,
                                   default: '0};

    // Private paths fall back to bypass while debug is locked out
    function automatic logic [3:0] eff_ir(input logic [3:0] ir, input logic dbg);
        logic [3:0] r;
        r = ir;
        if ((ir == IR_CPU || ir == IR_BRK || ir == IR_COMM) && !dbg) r = IR_BYPASS;
        if (!(ir inside {IR_EXTEST, IR_IDCODE, IR_SAMPLE, IR_CPU, IR_BRK, IR_COMM}))
            r = IR_BYPASS;
        return r;
    endfunction

    function automatic int dr_len(input logic [3:0] ir);
        case (ir)
            IR_IDCODE: return LEN_ID;
            IR_EXTEST, IR_SAMPLE: return BSW;
            IR_CPU: return LEN_CPU;
            IR_BRK: return DRW;
            IR_COMM: return LEN_COMM;
            default: return LEN_BYP;
        endcase
    endfunction

    function automatic jtd_tap_t tap_next(input jtd_tap_t st, input logic tms);
        case (st)
            TLR:   return tms ? TLR   : RTI;
            RTI:   return tms ? SELDR : RTI;
            SELDR: return tms ? SELIR : CAPDR;
            CAPDR: return tms ? EX1DR : SHDR;
            SHDR:  return tms ? EX1DR : SHDR;
            EX1DR: return tms ? UPDDR : PSDR;
            PSDR:  return tms ? EX2DR : PSDR;
            EX2DR: return tms ? UPDDR : SHDR;
            UPDDR: return tms ? SELDR : RTI;
            SELIR: return tms ? TLR   : CAPIR;
            CAPIR: return tms ? EX1IR : SHIR;
            SHIR:  return tms ? EX1IR : SHIR;
            EX1IR: return tms ? UPDIR : PSIR;
            PSIR:  return tms ? EX2IR : PSIR;
            EX2IR: return tms ? UPDIR : SHIR;
            UPDIR: return tms ? SELDR : RTI;
            default: return TLR;
        endcase
    endfunction
endpackage

//--- jtd_top.sv
// Test access port with debug chains and an APB control slave
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module jtd_top #(
    parameter logic [31:0] IDCODE_VAL = 32'h0000_0001 // Arbitrary value
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [7:0]               paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    output logic                          tdo,
    output logic                          tdo_oe_n,
    output logic                          pullup_en,
    input  wire logic                     test_port_enable_fuse,
    input  wire logic                     debug_enable_fuse,
    input  wire logic                     lock_bit_first,
    input  wire logic                     lock_bit_second,
    input  wire logic [jtd_pkg::BSW-1:0]  pin_in,
    output logic      [jtd_pkg::BSW-1:0]  bs_out,
    output logic                          bs_drive,
    input  wire logic [jtd_pkg::PCW-1:0]  cpu_pc,
    input  wire logic [jtd_pkg::PCW-1:0]  cpu_daddr,
    input  wire logic                     cpu_dacc,
    input  wire logic                     cpu_flow,
    input  wire logic                     cpu_step,
    output logic      [jtd_pkg::INW-1:0]  cpu_insn,
    output logic                          cpu_insn_valid,
    output logic                          break_req,
    output logic                          debug_active
);
    localparam int DRW = jtd_pkg::DRW;

    jtd_pkg::jtd_st_t s;
    jtd_pkg::jtd_st_t n;

    logic                    rise;
    logic                    fall;
    logic                    hold;
    logic                    t_ms;
    logic                    t_di;
    logic [3:0]              eir;
    int                      len;
    logic                    wr_ok;
    logic                    hit;
    logic [jtd_pkg::PCW-1:0] a2;
    logic [jtd_pkg::PCW-1:0] bpa [jtd_pkg::NBP];
    logic [jtd_pkg::NBP-1:0] bhit;

    //-----------------------------------------------------------------
    // Next-state logic
    //-----------------------------------------------------------------
    // All state advances here; TCK is only sampled, never used as a clock
    always_comb begin
        n = s;
        n.s1 = {tck, tms, tdi, test_port_enable_fuse, debug_enable_fuse,
                lock_bit_first, lock_bit_second};
        n.s2 = s.s1;
        n.tck_d = s.s2[jtd_pkg::SY_TCK];
        n.cpu_vld = 1'b0;
        rise = s.s2[jtd_pkg::SY_TCK] & ~s.tck_d;
        fall = ~s.s2[jtd_pkg::SY_TCK] & s.tck_d;
        t_ms = s.s2[jtd_pkg::SY_TMS];
        t_di = s.s2[jtd_pkg::SY_TDI];
        // Port gating by fuse and disable bit
        hold = ~s.s2[jtd_pkg::SY_TPF] | s.port_dis;
        n.pup = ~hold;
        n.dbg_act = ~hold & s.s2[jtd_pkg::SY_DBF] & ~s.s2[jtd_pkg::SY_LB1]
                    & ~s.s2[jtd_pkg::SY_LB2];
        eir = jtd_pkg::eff_ir(s.ir, s.dbg_act);
        len = jtd_pkg::dr_len(eir);

        // Controller actions on the rising test clock
        if (rise) begin
            case (s.tap)
                jtd_pkg::TLR: begin
                    n.ir = jtd_pkg::IR_IDCODE;
                end
                jtd_pkg::CAPIR: begin
                    n.ir_sh = jtd_pkg::IR_CAPTURE;
                end
                jtd_pkg::SHIR: begin
                    n.ir_sh = {t_di, s.ir_sh[jtd_pkg::IRW-1:1]};
                end
                jtd_pkg::UPDIR: begin
                    n.ir = s.ir_sh;
                end
                jtd_pkg::CAPDR: begin
                    // Bypass capture of zero clears the single stage
                    case (eir)
                        jtd_pkg::IR_IDCODE: n.dr = DRW'(IDCODE_VAL);
                        jtd_pkg::IR_EXTEST,
                        jtd_pkg::IR_SAMPLE: n.dr = DRW'(pin_in);
                        jtd_pkg::IR_CPU: n.dr = DRW'(cpu_pc);
                        jtd_pkg::IR_BRK: n.dr = s.bp_cfg;
                        jtd_pkg::IR_COMM: n.dr = DRW'({s.dirty, s.comm});
                        default: n.dr = '0;
                    endcase
                end
                jtd_pkg::SHDR: begin
                    n.dr = s.dr >> 1;
                    n.dr[len-1] = t_di;
                end
                jtd_pkg::UPDDR: begin
                    case (eir)
                        jtd_pkg::IR_EXTEST,
                        jtd_pkg::IR_SAMPLE: n.bs_out = s.dr[jtd_pkg::BSW-1:0];
                        jtd_pkg::IR_CPU: begin
                            n.cpu_insn = s.dr[jtd_pkg::INW-1:0];
                            n.cpu_vld = 1'b1;
                        end
                        jtd_pkg::IR_BRK: n.bp_cfg = s.dr;
                        default: n.bp_cfg = s.bp_cfg;
                    endcase
                end
                default: begin
                    n.dr = s.dr;
                end
            endcase
            n.tap = jtd_pkg::tap_next(s.tap, t_ms);
        end
        // Gating holds the controller in reset; no test reset pin exists
        if (hold) begin
            n.tap = jtd_pkg::TLR;
            n.ir = jtd_pkg::IR_IDCODE;
        end
        n.bs_drive = (eir == jtd_pkg::IR_EXTEST) && !hold;

        // Output pin moves on the falling test clock
        if (fall) begin
            n.tdo = (s.tap == jtd_pkg::SHIR) ? s.ir_sh[0] : s.dr[0];
            n.tdo_oe_n = ~((s.tap == jtd_pkg::SHIR) || (s.tap == jtd_pkg::SHDR));
        end
        if (hold) n.tdo_oe_n = 1'b1;

        // Break point unit, evaluated on the system clock
        for (int i = 0; i < jtd_pkg::NBP; i++) begin
            bpa[i] = s.bp_cfg[i*jtd_pkg::PCW +: jtd_pkg::PCW];
        end
        bhit[0] = (cpu_pc == bpa[0]);
        bhit[1] = (cpu_pc == bpa[1]);
        bhit[2] = s.bp_cfg[jtd_pkg::BF_D2] ? (cpu_dacc && cpu_daddr == bpa[2])
                                            : (cpu_pc == bpa[2]);
        bhit[3] = s.bp_cfg[jtd_pkg::BF_D3] ? (cpu_dacc && cpu_daddr == bpa[3])
                                            : (cpu_pc == bpa[3]);
        // Range mode: point two is the base, point three the care mask
        a2 = s.bp_cfg[jtd_pkg::BF_D2] ? cpu_daddr : cpu_pc;
        if (s.bp_cfg[jtd_pkg::BF_MASK]) begin
            bhit[2] = ((a2 ^ bpa[2]) & bpa[3]) == '0
                      && (cpu_dacc || !s.bp_cfg[jtd_pkg::BF_D2]);
            bhit[3] = 1'b0;
        end
        n.brk = s.dbg_act && ((|(bhit & s.bp_cfg[jtd_pkg::BF_EN +: jtd_pkg::NBP]))
                || (s.bp_cfg[jtd_pkg::BF_FLOW] && cpu_flow)
                || (s.bp_cfg[jtd_pkg::BF_STEP] && cpu_step));

        // APB slave: one wait state, answer in the second access cycle
        hit = paddr inside {jtd_pkg::A_CTRL, jtd_pkg::A_STAT, jtd_pkg::A_COMM};
        n.pready = psel & penable & ~s.pready;
        wr_ok = psel & penable & s.pready & pwrite;
        if (psel && penable && !s.pready) begin
            n.prdata = '0;
            n.pslverr = ~hit;
            if (!pwrite) begin
                case (paddr)
                    jtd_pkg::A_CTRL: n.prdata[jtd_pkg::CT_DIS] = s.port_dis;
                    jtd_pkg::A_STAT: begin
                        n.prdata[jtd_pkg::ST_TAP +: 4] = s.tap;
                        n.prdata[jtd_pkg::ST_IR +: jtd_pkg::IRW] = s.ir;
                        n.prdata[jtd_pkg::ST_PUP] = s.pup;
                        n.prdata[jtd_pkg::ST_DBG] = s.dbg_act;
                        n.prdata[jtd_pkg::ST_DIRT] = s.dirty;
                        n.prdata[jtd_pkg::ST_BRK] = s.brk;
                    end
                    jtd_pkg::A_COMM: begin
                        n.prdata[jtd_pkg::CMW-1:0] = s.comm;
                        n.prdata[jtd_pkg::CM_DIRT] = s.dirty;
                    end
                    default: n.prdata = '0;
                endcase
            end
        end
        if (wr_ok && paddr == jtd_pkg::A_CTRL) n.port_dis = pwdata[jtd_pkg::CT_DIS];
        // A debugger read clears the dirty flag, but a new write wins
        if (rise && s.tap == jtd_pkg::UPDDR && eir == jtd_pkg::IR_COMM)
            n.dirty = 1'b0;
        if (wr_ok && paddr == jtd_pkg::A_COMM) begin
            n.comm = pwdata[jtd_pkg::CMW-1:0];
            n.dirty = 1'b1;
        end
    end

    //-----------------------------------------------------------------
    // State register
    //-----------------------------------------------------------------
    // Reset lands in Test-Logic-Reset with the ID path selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= jtd_pkg::RST_ST;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from flops
    assign prdata         = s.prdata;
    assign pready         = s.pready;
    assign pslverr        = s.pslverr;
    assign tdo            = s.tdo;
    assign tdo_oe_n       = s.tdo_oe_n;
    assign pullup_en      = s.pup;
    assign bs_out         = s.bs_out;
    assign bs_drive       = s.bs_drive;
    assign cpu_insn       = s.cpu_insn;
    assign cpu_insn_valid = s.cpu_vld;
    assign break_req      = s.brk;
    assign debug_active   = s.dbg_act;

    //-----------------------------------------------------------------
    // Checks
    //-----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Count of consecutive TMS-high test clocks, saturating
    logic [2:0] tms_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tms_cnt <= 3'h0;
        end else if (rise) begin
            tms_cnt <= !t_ms ? 3'h0 : (tms_cnt == 3'h7) ? 3'h7 : tms_cnt + 3'h1;
        end
    end

    sequence s_rise_in(jtd_pkg::jtd_tap_t st);
        rise && s.tap == st;
    endsequence

    sequence s_apb_start;
        psel && penable && !s.pready;
    endsequence

    a_hold_reset: assert property (hold |=> s.tap == jtd_pkg::TLR)
        else $error("controller not held in reset");
    a_five_tms: assert property (tms_cnt >= 3'h5 |-> s.tap == jtd_pkg::TLR)
        else $error("five TMS highs did not reset");
    a_ir_capture: assert property (s_rise_in(jtd_pkg::CAPIR) |=>
        s.ir_sh == jtd_pkg::IR_CAPTURE)
        else $error("instruction capture value wrong");
    a_ir_update: assert property (s.ir != $past(s.ir) |->
        $past(s.tap) inside {jtd_pkg::UPDIR, jtd_pkg::TLR} || $past(hold))
        else $error("instruction changed outside update");
    a_bypass_zero: assert property (s_rise_in(jtd_pkg::CAPDR) && eir == jtd_pkg::IR_BYPASS
        |=> s.dr[0] == 1'b0)
        else $error("bypass stage not cleared");
    a_pause_quiet: assert property (rise && s.tap inside {jtd_pkg::EX1DR, jtd_pkg::PSDR,
        jtd_pkg::EX2DR, jtd_pkg::EX1IR, jtd_pkg::PSIR, jtd_pkg::EX2IR}
        |=> $stable(s.dr) && $stable(s.ir_sh) && $stable(s.ir))
        else $error("register action in exit or pause");
    a_tdo_fall: assert property (s.tdo != $past(s.tdo) |-> $past(fall))
        else $error("data out moved off a falling edge");
    a_tdo_drive: assert property (!s.tdo_oe_n |->
        s.tap inside {jtd_pkg::SHIR, jtd_pkg::SHDR, jtd_pkg::EX1IR, jtd_pkg::EX1DR})
        else $error("data out driven outside a shift");
    a_dr_update: assert property (s.bs_out != $past(s.bs_out) |->
        $past(s.tap) == jtd_pkg::UPDDR)
        else $error("boundary latch moved outside update");
    a_dbg_gate: assert property (s.dbg_act |-> s.s2[jtd_pkg::SY_DBF] ||
        $past(s.s2[jtd_pkg::SY_DBF]))
        else $error("debug active without its fuse");
    a_shift_lsb: assert property (s_rise_in(jtd_pkg::SHIR) |=>
        s.ir_sh[jtd_pkg::IRW-2:0] == $past(s.ir_sh[jtd_pkg::IRW-1:1]))
        else $error("instruction shift not LSB first");
    a_apb_ready: assert property (s_apb_start |=> pready ##1 !pready)
        else $error("APB answer not one cycle");
endmodule // jtd_top

//--- jtd_host.sv
// Behavioural test-port controller that drives the link pins
`timescale 1ns/1ps
module jtd_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // Link clock stands low between frames; idle pins sit at the pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One 400 ns period: pins move while low, tdo taken just after the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #200 tck = 1'b1;
        #50 q = tdo;
        #150 tck = 1'b0;
    endtask

    // Five high periods from anywhere, then settle in idle
    task automatic reset5();
        logic q;
        for (int i = 0; i < 5; i++) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask

    // Scan from idle and back to idle; last bit shifts as the shift state is left
    task automatic scan(input logic ir, input int n, input logic [72:0] din,
                        output logic [72:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~din[n-1], q);
        step(1'b0, din[n-1], q);
    endtask
endmodule // jtd_host

//--- tb.sv
// Self-checking bench of the test access port and its register slave
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] ID = 32'h1357_9bdf; // Arbitrary value, LSB set
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, pin_in, bs_out;
    logic [31:0] pwdata, prdata, rd;
    logic        tck, tms, tdi, tdo, tdo_oe_n, tdo_w, pullup_en, bs_drive, err;
    logic        tpf, dbf, lb1, lb2, cpu_dacc, cpu_flow, cpu_step;
    logic [15:0] cpu_pc, cpu_daddr, cpu_insn;
    logic        cpu_insn_valid, break_req, debug_active;
    logic [72:0] d;
    int          num_errors = 0;
    int          comparisons = 0;
    logic        vseen = 1'b0;

    // The valid strobe stands one cycle only, so it is caught in a sticky flag
    always @(posedge pclk) begin
        if (cpu_insn_valid === 1'b1) vseen <= 1'b1;
    end

    // Pin has a pull-up, so a released tdo reads high
    assign tdo_w = tdo_oe_n ? 1'b1 : tdo;

    jtd_top #(.IDCODE_VAL(ID)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pullup_en(pullup_en),
        .test_port_enable_fuse(tpf), .debug_enable_fuse(dbf), .lock_bit_first(lb1),
        .lock_bit_second(lb2), .pin_in(pin_in), .bs_out(bs_out), .bs_drive(bs_drive),
        .cpu_pc(cpu_pc), .cpu_daddr(cpu_daddr), .cpu_dacc(cpu_dacc),
        .cpu_flow(cpu_flow), .cpu_step(cpu_step), .cpu_insn(cpu_insn),
        .cpu_insn_valid(cpu_insn_valid), .break_req(break_req),
        .debug_active(debug_active));
    jtd_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

    //------------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------------
    task automatic check(input logic [72:0] seen, input logic [72:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is seen high; bounded wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) num_errors++;
        // Step off the edge so the next link step never races the sampler
        #13;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // Load an instruction; the captured value always comes out
    task automatic ir(input logic [3:0] c);
        host.scan(1'b1, 4, {69'h0, c}, d);
        check(d[3:0], 4'h1);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    //------------------------------------------------------------------
    // Clock, watchdog and main sequence
    //------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Whole sequence needs well under a quarter of this span
    initial begin
        #2000000;
        num_errors++;
        summarize();
    end

    initial begin
        {presetn, psel, penable, pwrite, lb1, lb2, cpu_dacc, cpu_flow, cpu_step} = '0;
        {tpf, dbf} = 2'b11;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pin_in = 8'h00;
        cpu_pc = 16'h0000;
        cpu_daddr = 16'h0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rchk(8'h04, 32'h0000_0310);
        #13;
        host.reset5();
        rchk(8'h04, 32'h0000_0311);
        host.scan(1'b0, 32, 73'h0, d);
        check(d[31:0], ID);
        ir(4'hf);
        rchk(8'h04, 32'h0000_03f1);
        host.scan(1'b0, 8, 73'h5a, d);
        check(d[7:0], 8'hb4);
        pin_in <= 8'hc3;
        ir(jtd_pkg::IR_SAMPLE);
        host.scan(1'b0, 8, 73'h3c, d);
        check(d[7:0], 8'hc3);
        ir(jtd_pkg::IR_EXTEST);
        host.scan(1'b0, 8, 73'h96, d);
        check({bs_drive, bs_out}, 9'h196);
        cpu_pc <= 16'h1234;
        ir(jtd_pkg::IR_CPU);
        host.scan(1'b0, 16, 73'hbeef, d);
        check({d[15:0], cpu_insn}, 32'h1234_beef);
        check(vseen, 1'b1);
        apb(1'b1, 8'h08, 32'h0000_0041);
        rchk(8'h08, 32'h0000_00c1);
        ir(jtd_pkg::IR_COMM);
        host.scan(1'b0, 9, 73'h0, d);
        check(d[8:0], 9'h141);
        rchk(8'h08, 32'h0000_0041);
        cpu_pc <= 16'h0200;
        ir(jtd_pkg::IR_BRK);
        host.scan(1'b0, 73, {2'b01, 6'h00, 1'b1, 48'h0, 16'h0200}, d);
        repeat (3) @(posedge pclk);
        check(break_req, 1'b1);
        cpu_pc <= 16'h0202;
        repeat (3) @(posedge pclk);
        check(break_req, 1'b0);
        cpu_flow <= 1'b1;
        repeat (3) @(posedge pclk);
        check(break_req, 1'b1);
        cpu_flow <= 1'b0;
        repeat (3) @(posedge pclk);
        check(break_req, 1'b0);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        check({err, rd}, 33'h1_0000_0000);
        lb1 <= 1'b1;
        repeat (5) @(posedge pclk);
        check(debug_active, 1'b0);
        lb1 <= 1'b0;
        apb(1'b1, 8'h00, 32'h0000_0001);
        repeat (5) @(posedge pclk);
        check({pullup_en, tdo_oe_n}, 2'b01);
        rchk(8'h04, 32'h0000_0010);
        apb(1'b1, 8'h00, 32'h0000_0000);
        tpf <= 1'b0;
        repeat (5) @(posedge pclk);
        check(pullup_en, 1'b0);
        tpf <= 1'b1;
        repeat (5) @(posedge pclk);
        check(pullup_en, 1'b1);
        summarize();
    end
endmodule // tb
